// ==== hge_csr_bank.sv ====
// Hypervisor guest environment register bank with guest qualifiers.
// Assumes hart logic on the same clock drives the trap and access inputs;
// software reaches the registers over a single-slave AHB-Lite port.
//
// Contract
// - Provide a 64-bit read/write environment configuration, effective when virtualized.
// - Timer compare bit 63, page attribute 62, A/D update 61, double trap 59.
// - Fence bit 0, landing pad 2, shadow stack 3, cache bits 4,5,7, masking 33:32.
// - Fence I/O bits also cover memory reads/writes when enabled and virtualized.
// - Ordered atomics to device I/O also order memory under that setting.
// - Page attributes usable in guest translation only when enabled; else absent.
// - A/D hardware update when enabled, fault on update when disabled.
// - Landing pad disabled keeps not-expected state, landing pad instruction no-op.
// - Shadow stack disabled: fallback operations, write-only encoding becomes reserved.
// - Shadow stack disabled: guest supervisor enable reads zero; swap may fault.
// - Double trap disabled: guest supervisor double-trap bit reads zero.
// - On 32-bit harts an alias exposes upper configuration bits 63:32.
// - Guest counter read with clear bit and machine bit set faults.
// - Guest user counter read needs both hypervisor and supervisor bits.
// - Counter-enable bits may be hardwired zero; their counters always fault; cntFault rises only with the machine bit set.
// - Guest time reads return real time plus offset modulo 2^64.
// - On 32-bit harts an alias exposes offset bits 63:32.
// - Trap into HS writes address register: shifted fault address or zero.
// - Implicit translation access faults record the implicit access address.
// - Nonzero address matches faulting portion of misaligned or split access.
// - 32-bit harts record guest address bits 33:2; the code records bits GPA_BITS-1:2 whatever XLEN.
// - Trap address register is write-any read-legal and can hold zero.
`timescale 1ns/10ps
module hge_csr_bank
   import hge_pkg::*;
#(
   parameter int XLEN = 64,
   parameter bit HAS_PBMT = 1'b1,
   parameter bit HAS_ADU = 1'b1,
   parameter logic [31:0] CNTEN_MASK = 32'hffff_ffff,
   parameter int GPA_BITS = 56
) (
   input wire logic clock,
   input wire logic rstn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire logic virtMode,
   input wire logic guestUser,
   input wire logic [63:0] realTime,
   input wire logic [31:0] machCntEn,
   input wire logic [31:0] supCntEn,
   input wire logic cntRead,
   input wire logic [4:0] cntIndex,
   input wire logic machSse,
   input wire logic ssSwap,
   input wire logic [3:0] fenceSet,
   input wire logic atomicOrdered,
   input wire logic atomicToIo,
   input wire logic [2:0] pteXwr,
   input wire logic trapToHs,
   input wire logic trapGuestPage,
   input wire logic trapImplicit,
   input wire logic [63:0] gpaOriginal,
   input wire logic [63:0] gpaImplicit,
   output logic [63:0] envCfg,
   output logic [63:0] guestTime,
   output logic cntFault,
   output logic [3:0] fenceMemSet,
   output logic atomicAlsoMem,
   output logic pageAttrUsable,
   output logic adHwUpdate,
   output logic adFault,
   output logic lpActive,
   output logic ssActive,
   output logic xwrReserved,
   output logic guestSseRoZero,
   output logic ssSwapFault,
   output logic guestSdtRoZero
);
   initial begin
      if (XLEN != 32 && XLEN != 64)
         $error("XLEN must be 32 or 64");
      if (GPA_BITS < 3 || GPA_BITS > 64)
         $error("GPA_BITS out of range");
   end

   localparam logic [63:0] GPA_MASK = (GPA_BITS >= 64) ? ~HGE_ZERO64 :
      ((64'h1 << (GPA_BITS - HGE_GPA_SHIFT)) - 64'h1);

   // lower field positions.
   // Writable configuration fields; the remaining bits are reserved and
   // read as zero, so writes cannot change them.
   localparam logic [63:0] ENV_WMASK =
      (64'h1 << HGE_B_IO_FENCE_IMPLIES_MEMORY) | (64'h1 << HGE_B_LPE) | (64'h1 << HGE_B_SSE) |
      (64'h1 << HGE_B_CACHE_BLOCK_INVALIDATE_ENABLE) | (64'h1 << HGE_B_CACHE_BLOCK_CLEAN_FLUSH_ENABLE) |
      (64'h1 << HGE_B_CACHE_BLOCK_ZERO_ENABLE) | (64'h1 << HGE_B_PMM_LO) |
      (64'h1 << HGE_B_PMM_HI) | (64'h1 << HGE_B_DTE) |
      (64'h1 << HGE_B_SUPERVISOR_TIMER_COMPARE_ENABLE) | (64'(HAS_ADU) << HGE_B_HW_ACCESS_DIRTY_UPDATE_ENABLE) |
      (64'(HAS_PBMT) << HGE_B_PAGE_ATTR_ENABLE);

   logic [63:0] envCfg_r;
   logic [31:0] cntEn_r;
   logic [63:0] tDelta_r;
   logic [63:0] tVal_r;
   logic wrPend_r;
   logic [7:0] wrAddr_r;
   logic [31:0] rdData_nxt;
   logic [63:0] tvalTrap;
   logic [63:0] sumTime;
   logic addrOk;
   logic wrHit;

   assign addrOk = hsel && hready && htrans == HGE_HTRANS_NONSEQ;
   assign wrHit = wrPend_r;
   assign sumTime = realTime + tDelta_r;

   // Capture address phase of a write; data follows next cycle.
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         wrPend_r <= 1'b0;
         wrAddr_r <= 8'h00;
      end else begin
         wrPend_r <= addrOk && hwrite;
         if (addrOk)
            wrAddr_r <= haddr[7:0];
      end
   end

   // upper alias at HGE_ENVCFG_HI on every hart, whatever XLEN.
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         envCfg_r <= HGE_ZERO64;
      end else if (wrHit && wrAddr_r == HGE_ENVCFG_LO) begin
         envCfg_r[31:0] <= hwdata & ENV_WMASK[31:0];
      end else if (wrHit && wrAddr_r == HGE_ENVCFG_HI) begin
         envCfg_r[63:32] <= hwdata & ENV_WMASK[63:32];
      end
   end

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn)
         cntEn_r <= HGE_ZERO32;
      else if (wrHit && wrAddr_r == HGE_CNTEN)
         cntEn_r <= hwdata & CNTEN_MASK;
   end

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn)
         tDelta_r <= HGE_ZERO64;
      else if (wrHit && wrAddr_r == HGE_TDELTA_LO)
         tDelta_r[31:0] <= hwdata;
      else if (wrHit && wrAddr_r == HGE_TDELTA_HI)
         tDelta_r[63:32] <= hwdata;
   end

   always_comb begin
      tvalTrap = HGE_ZERO64;
      if (trapGuestPage) begin
         if (trapImplicit)
            tvalTrap = (gpaImplicit >> HGE_GPA_SHIFT) & GPA_MASK;
         else
            tvalTrap = (gpaOriginal >> HGE_GPA_SHIFT) & GPA_MASK;
      end
   end

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn)
         tVal_r <= HGE_ZERO64;
      else if (trapToHs)
         tVal_r <= tvalTrap;
      else if (wrHit && wrAddr_r == HGE_TVAL_LO)
         tVal_r[31:0] <= hwdata & GPA_MASK[31:0];
      else if (wrHit && wrAddr_r == HGE_TVAL_HI)
         tVal_r[63:32] <= hwdata & GPA_MASK[63:32];
   end

   always_comb begin
      rdData_nxt = HGE_ZERO32;
      unique case (haddr[7:0])
         HGE_ENVCFG_LO: rdData_nxt = envCfg_r[31:0];
         HGE_ENVCFG_HI: rdData_nxt = envCfg_r[63:32];
         HGE_CNTEN: rdData_nxt = cntEn_r;
         HGE_TDELTA_LO: rdData_nxt = tDelta_r[31:0];
         HGE_TDELTA_HI: rdData_nxt = tDelta_r[63:32];
         HGE_TVAL_LO: rdData_nxt = tVal_r[31:0];
         HGE_TVAL_HI: rdData_nxt = tVal_r[63:32];
         HGE_TIME_LO: rdData_nxt = sumTime[31:0];
         HGE_TIME_HI: rdData_nxt = sumTime[63:32];
         default: rdData_nxt = HGE_ZERO32;
      endcase
   end

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         hrdata <= HGE_ZERO32;
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end else begin
         if (addrOk && !hwrite)
            hrdata <= rdData_nxt;
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end
   end

   // Qualifiers registered so every output is a flop; the hart sees them
   // one cycle after its request, a latency it must plan for.
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         envCfg <= HGE_ZERO64;
         guestTime <= HGE_ZERO64;
      end else begin
         envCfg <= envCfg_r;
         guestTime <= sumTime;
      end
   end

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         cntFault <= 1'b0;
      end else begin
         cntFault <= cntRead && virtMode && machCntEn[cntIndex] &&
            (!cntEn_r[cntIndex] || (guestUser && !supCntEn[cntIndex]));
      end
   end

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         fenceMemSet <= 4'h0;
         atomicAlsoMem <= 1'b0;
      end else begin
         fenceMemSet <= (virtMode && envCfg_r[HGE_B_IO_FENCE_IMPLIES_MEMORY]) ? fenceSet : 4'h0;
         atomicAlsoMem <= virtMode && envCfg_r[HGE_B_IO_FENCE_IMPLIES_MEMORY] &&
            atomicOrdered && atomicToIo;
      end
   end

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         pageAttrUsable <= 1'b0;
         adHwUpdate <= 1'b0;
         adFault <= 1'b0;
      end else begin
         pageAttrUsable <= virtMode && envCfg_r[HGE_B_PAGE_ATTR_ENABLE];
         adHwUpdate <= virtMode && envCfg_r[HGE_B_HW_ACCESS_DIRTY_UPDATE_ENABLE];
         adFault <= virtMode && !envCfg_r[HGE_B_HW_ACCESS_DIRTY_UPDATE_ENABLE];
      end
   end

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         lpActive <= 1'b0;
         ssActive <= 1'b0;
         xwrReserved <= 1'b0;
         guestSseRoZero <= 1'b0;
         ssSwapFault <= 1'b0;
         guestSdtRoZero <= 1'b0;
      end else begin
         lpActive <= virtMode && envCfg_r[HGE_B_LPE];
         ssActive <= virtMode && envCfg_r[HGE_B_SSE];
         xwrReserved <= virtMode && !envCfg_r[HGE_B_SSE] &&
            pteXwr == HGE_XWR_WONLY;
         guestSseRoZero <= !envCfg_r[HGE_B_SSE];
         ssSwapFault <= virtMode && !envCfg_r[HGE_B_SSE] && machSse &&
            ssSwap;
         guestSdtRoZero <= !envCfg_r[HGE_B_DTE];
      end
   end
endmodule

// ==== hge_pkg.sv ====
// Constants for the hypervisor guest environment register bank.
// Assumes a single hart clock and an AHB-Lite register port.
package hge_pkg;
   // Register byte offsets (one aligned word each).
   localparam logic [7:0] HGE_ENVCFG_LO = 8'h00;
   localparam logic [7:0] HGE_ENVCFG_HI = 8'h04;
   localparam logic [7:0] HGE_CNTEN = 8'h08;
   localparam logic [7:0] HGE_TDELTA_LO = 8'h0c;
   localparam logic [7:0] HGE_TDELTA_HI = 8'h10;
   localparam logic [7:0] HGE_TVAL_LO = 8'h14;
   localparam logic [7:0] HGE_TVAL_HI = 8'h18;
   localparam logic [7:0] HGE_TIME_LO = 8'h1c;
   localparam logic [7:0] HGE_TIME_HI = 8'h20;
   // Field positions in the environment configuration register.
   localparam int HGE_B_IO_FENCE_IMPLIES_MEMORY = 0;
   localparam int HGE_B_LPE = 2;
   localparam int HGE_B_SSE = 3;
   localparam int HGE_B_CACHE_BLOCK_INVALIDATE_ENABLE = 4;
   localparam int HGE_B_CACHE_BLOCK_CLEAN_FLUSH_ENABLE = 5;
   localparam int HGE_B_CACHE_BLOCK_ZERO_ENABLE = 7;
   localparam int HGE_B_PMM_LO = 32;
   localparam int HGE_B_PMM_HI = 33;
   localparam int HGE_B_DTE = 59;
   localparam int HGE_B_HW_ACCESS_DIRTY_UPDATE_ENABLE = 61;
   localparam int HGE_B_PAGE_ATTR_ENABLE = 62;
   localparam int HGE_B_SUPERVISOR_TIMER_COMPARE_ENABLE = 63;
   localparam int HGE_TIME_BIT = 1;
   localparam int HGE_GPA_SHIFT = 2;
   localparam logic [2:0] HGE_XWR_WONLY = 3'b010;
   localparam logic [63:0] HGE_ZERO64 = 64'h0;
   localparam logic [31:0] HGE_ZERO32 = 32'h0;
   localparam logic [1:0] HGE_HTRANS_NONSEQ = 2'b10;
   localparam logic [2:0] HGE_HSIZE_WORD = 3'b010;
endpackage

// ==== hge_hart_model.sv ====
// Stand-in for the hart: free-running real time and trap pulses.
// Assumes the bench calls trap() from its main sequence.
`timescale 1ns/10ps
module hge_hart_model (
   input wire logic clock,
   input wire logic rstn,
   output logic [63:0] realTime,
   output logic trapToHs,
   output logic trapGuestPage,
   output logic trapImplicit,
   output logic [63:0] gpaOriginal,
   output logic [63:0] gpaImplicit
);
   initial begin
      {trapToHs, trapGuestPage, trapImplicit} = 3'h0;
      {gpaOriginal, gpaImplicit} = '0;
   end
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         realTime <= 64'h0;
      end else begin
         realTime <= realTime + 64'h1;
      end
   end
   // Addresses mean nothing outside the pulse, so they are inverted then.
   task automatic trap(input logic g, input logic i, input logic [63:0] a,
                       input logic [63:0] b);
      @(posedge clock);
      {trapToHs, trapGuestPage, trapImplicit} <= {1'b1, g, i};
      {gpaOriginal, gpaImplicit} <= {a, b};
      @(posedge clock);
      {trapToHs, trapGuestPage, trapImplicit} <= 3'h0;
      {gpaOriginal, gpaImplicit} <= ~{a, b};
   endtask
endmodule

// ==== hge_csr_bank_asserts.sv ====
// Checks on the guest qualifier outputs of the register bank.
// Assumes every qualifier output follows its cause by one cycle.
`timescale 1ns/10ps
module hge_csr_bank_asserts (
   input wire logic clock,
   input wire logic rstn,
   input wire logic virtMode,
   input wire logic [63:0] envCfg,
   input wire logic [3:0] fenceSet,
   input wire logic [3:0] fenceMemSet,
   input wire logic pageAttrUsable,
   input wire logic lpActive,
   input wire logic cntRead,
   input wire logic [4:0] cntIndex,
   input wire logic [31:0] machCntEn,
   input wire logic cntFault,
   input wire logic machSse,
   input wire logic ssSwap,
   input wire logic ssSwapFault,
   input wire logic guestSseRoZero,
   input wire logic guestSdtRoZero
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rstn);
   // Two samples low cover both a direct and a registered config copy.
   sequence s_low2(b);
      !b ##1 !b;
   endsequence
   a_fence_widen: assert property (
      (virtMode && envCfg[0]) ##1 envCfg[0] |-> fenceMemSet == $past(fenceSet))
      else $error("fence set not widened");
   a_fence_guest: assert property (
      !virtMode |=> fenceMemSet == 4'h0) else $error("fence widened outside");
   a_attr_gate: assert property (
      pageAttrUsable |-> envCfg[62] || $past(envCfg[62]))
      else $error("page attributes usable while disabled");
   a_lp_gate: assert property (
      lpActive |-> envCfg[2] || $past(envCfg[2])) else $error("landing pad on");
   a_sse_zero: assert property (
      rstn ##1 s_low2(envCfg[3]) |-> guestSseRoZero)
      else $error("guest sse writable");
   a_swap_fault: assert property (
      ssSwapFault |-> $past(ssSwap && machSse)) else $error("bad swap fault");
   a_dte_zero: assert property (
      rstn ##1 s_low2(envCfg[59]) |-> guestSdtRoZero)
      else $error("guest sdt writable");
   a_cnt_cause: assert property (
      cntFault |-> $past(cntRead && virtMode && machCntEn[cntIndex]))
      else $error("counter fault without cause");
endmodule
bind hge_csr_bank hge_csr_bank_asserts hge_csr_bank_asserts_inst (.clock,
   .rstn, .virtMode, .envCfg, .fenceSet, .fenceMemSet, .pageAttrUsable,
   .lpActive, .cntRead, .cntIndex, .machCntEn, .cntFault, .machSse, .ssSwap,
   .ssSwapFault, .guestSseRoZero, .guestSdtRoZero);

// ==== hge_csr_bank_test.sv ====
// Self-checking bench: AHB-Lite register tasks plus hart-side levels.
// Assumes the bank answers with zero wait states but never relies on it.
`timescale 1ns/10ps
module hge_csr_bank_test
   import hge_pkg::*;
;
   logic clock = 1'b0, rstn = 1'b0, hsel, hwrite, hready, hreadyout, hresp;
   logic [31:0] haddr, hwdata, hrdata, machCntEn, supCntEn, rd;
   logic [1:0] htrans;
   logic [2:0] hsize, pteXwr;
   logic [3:0] fenceSet, fenceMemSet;
   logic [4:0] cntIndex;
   logic virtMode, guestUser, cntRead, machSse, ssSwap, atomicOrdered;
   logic atomicToIo, trapToHs, trapGuestPage, trapImplicit, cntFault;
   logic atomicAlsoMem, pageAttrUsable, adHwUpdate, adFault, lpActive;
   logic ssActive, xwrReserved, guestSseRoZero, ssSwapFault, guestSdtRoZero;
   logic [63:0] realTime, gpaOriginal, gpaImplicit, envCfg, guestTime;
   int fails = 0, cmp_count = 0;
   always #20 clock = ~clock;
   assign hready = hreadyout;
   hge_csr_bank hge_csr_bank_inst (.clock, .rstn, .hsel, .haddr, .htrans,
      .hwrite, .hsize, .hwdata, .hready, .hrdata, .hreadyout, .hresp,
      .virtMode, .guestUser, .realTime, .machCntEn, .supCntEn, .cntRead,
      .cntIndex, .machSse, .ssSwap, .fenceSet, .atomicOrdered, .atomicToIo,
      .pteXwr, .trapToHs, .trapGuestPage, .trapImplicit, .gpaOriginal,
      .gpaImplicit, .envCfg, .guestTime, .cntFault, .fenceMemSet,
      .atomicAlsoMem, .pageAttrUsable, .adHwUpdate, .adFault, .lpActive,
      .ssActive, .xwrReserved, .guestSseRoZero, .ssSwapFault, .guestSdtRoZero);
   hge_hart_model hge_hart_model_inst (.clock, .rstn, .realTime, .trapToHs,
      .trapGuestPage, .trapImplicit, .gpaOriginal, .gpaImplicit);
   task automatic check(input logic [63:0] seen, input logic [63:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         fails++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic end_of_test();
      $display("compares %0d mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   task automatic waitReady();
      int n = 0;
      @(posedge clock);
      while (hreadyout !== 1'b1) begin
         n++;
         if (n > 50) begin
            fails++;
            end_of_test();
         end
         @(posedge clock);
      end
   endtask
   // The leading edge doubles as the idle cycle a read after a write needs.
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clock);
      {hsel, haddr, htrans, hwrite} <= {1'b1, 24'h0, a, HGE_HTRANS_NONSEQ, w};
      waitReady();
      {hsel, htrans, hwdata} <= {1'b0, 2'b00, d};
      waitReady();
      rd = hrdata;
   endtask
   task automatic rdChk(input logic [7:0] a, input logic [31:0] exp);
      xfer(1'b0, a, 32'h0);
      check({32'h0, rd}, {32'h0, exp});
   endtask
   task automatic settle();
      repeat (2) @(posedge clock);
      #1;
   endtask
   initial begin
      {hsel, hwrite, cntRead, virtMode, guestUser, machSse, ssSwap} = '0;
      {atomicOrdered, atomicToIo, haddr, hwdata, htrans, fenceSet} = '0;
      {machCntEn, supCntEn, cntIndex, pteXwr} = '0;
      hsize = HGE_HSIZE_WORD;
      repeat (3) @(posedge clock);
      rstn <= 1'b1;
      xfer(1'b1, 8'h24, 32'hffff_ffff);
      for (int i = 0; i <= 28; i += 4) begin
         rdChk(i == 28 ? 8'h24 : i[7:0], 32'h0);
      end
      $display("test reset done");
      xfer(1'b1, HGE_ENVCFG_LO, 32'hffff_ffff);
      xfer(1'b1, HGE_ENVCFG_HI, 32'hffff_ffff);
      rdChk(HGE_ENVCFG_LO, 32'h0000_00bd);
      rdChk(HGE_ENVCFG_HI, 32'he800_0003);
      check(envCfg, 64'he800_0003_0000_00bd);
      {virtMode, fenceSet, atomicOrdered, atomicToIo} <= {1'b1, 4'ha, 2'b11};
      {pteXwr, machSse, ssSwap} <= {HGE_XWR_WONLY, 2'b11};
      settle();
      check({fenceMemSet, atomicAlsoMem}, 5'h15);
      check({pageAttrUsable, adHwUpdate, lpActive, ssActive}, 4'hf);
      check({xwrReserved, guestSseRoZero, ssSwapFault, guestSdtRoZero}, 0);
      xfer(1'b1, HGE_ENVCFG_LO, 32'h0);
      xfer(1'b1, HGE_ENVCFG_HI, 32'h0);
      settle();
      check({fenceMemSet, atomicAlsoMem, pageAttrUsable, adHwUpdate}, 0);
      check({lpActive, ssActive, xwrReserved, guestSseRoZero}, 4'h3);
      check({ssSwapFault, guestSdtRoZero}, 2'h3);
      check({adFault, hresp, hreadyout}, 3'h5);
      $display("test config done");
      xfer(1'b1, HGE_CNTEN, 32'h5);
      rdChk(HGE_CNTEN, 32'h5);
      supCntEn <= 32'h1;
      for (int k = 0; k < 7; k++) begin
         @(posedge clock);
         {machCntEn, guestUser, cntRead} <= {{32{k < 6}}, k > 2, 1'b1};
         cntIndex <= 5'(k == 6 ? 1 : k % 3);
         @(posedge clock);
         cntRead <= 1'b0;
         #1 check(cntFault, k < 6 && (k % 3 == 1 || k == 5));
      end
      $display("test counters done");
      xfer(1'b1, HGE_TDELTA_LO, 32'hffff_f000);
      xfer(1'b1, HGE_TDELTA_HI, 32'hffff_ffff);
      rdChk(HGE_TDELTA_HI, 32'hffff_ffff);
      #1 check(guestTime, realTime - 64'h1001);
      $display("test time done");
      hge_hart_model_inst.trap(1'b1, 1'b0, 64'h1234_5678, 64'h0);
      rdChk(HGE_TVAL_LO, 32'h048d_159e);
      hge_hart_model_inst.trap(1'b1, 1'b1, 64'h0, 64'hab_cdef_0120);
      rdChk(HGE_TVAL_LO, 32'hf37b_c048);
      rdChk(HGE_TVAL_HI, 32'h0000_002a);
      hge_hart_model_inst.trap(1'b0, 1'b0, 64'hff, 64'hff);
      rdChk(HGE_TVAL_LO, 32'h0);
      xfer(1'b1, HGE_TVAL_HI, 32'hffff_ffff);
      rdChk(HGE_TVAL_HI, 32'h003f_ffff);
      xfer(1'b1, HGE_ENVCFG_LO, 32'h1);
      virtMode <= 1'b0;
      settle();
      check(fenceMemSet, 4'h0);
      $display("test trap done");
      end_of_test();
   end
endmodule
